// ===== logic/dac_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dac_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             srst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} dac_fifo_s;
	dac_fifo_s            st_q;
	dac_fifo_s            st_d;
	logic [WIDTH-1:0]     mem_q [DEPTH];
	logic                 push;
	logic                 pop;

	assign in_ready  = (st_q.cnt != DEPTH[AW:0]);
	assign out_valid = (st_q.cnt != '0);
	assign out_data  = mem_q[st_q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		st_d = st_q;
		if (push) st_d.wp = (st_q.wp == AW'(DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
		if (pop) st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) st_q <= '0;
		else st_q <= st_d;
		if (push) mem_q[st_q.wp] <= in_data;
	end
endmodule
`default_nettype wire

// ===== logic/dac_out_ctrl.sv
// Output stage of a dual 12-bit converter: coding, strap decode, power modes, swap.
// Assumes sample clocks are synchronous strobes sampled on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dac_out_ctrl
	import dac_pkg::*;
#(
	parameter int PIPE_LATENCY  = PIPE_LAT,
	parameter int SLEEP_WAKE    = SLEEP_WAKE_CYC,
	parameter int NAP_WAKE      = NAP_WAKE_CYC
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              srst,
	// Sample clocks and converter cores
	input  wire logic              chan_a_sample_clock,
	input  wire logic              chan_b_sample_clock,
	input  wire logic [11:0]       chan_a_raw,
	input  wire logic              chan_a_over,
	input  wire logic              chan_a_under,
	input  wire logic [11:0]       chan_b_raw,
	input  wire logic              chan_b_over,
	input  wire logic              chan_b_under,
	// Control pins
	input  wire logic [1:0]        format_strap,
	input  wire logic              chan_a_output_enable_n,
	input  wire logic              chan_b_output_enable_n,
	input  wire logic              chan_a_power_down,
	input  wire logic              chan_b_power_down,
	input  wire logic              bus_swap_select,
	// Output buses
	output logic [11:0]            bus_a_data,
	output logic                   bus_a_range_flag,
	output logic                   bus_a_oe,
	output logic [11:0]            bus_b_data,
	output logic                   bus_b_range_flag,
	output logic                   bus_b_oe,
	// Status
	output logic                   twos_comp,
	output logic                   stabilizer_on,
	output logic                   stabilizer_locked,
	output logic [1:0]             chan_a_valid,
	output logic [1:0]             chan_b_valid
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0]    clk_prev;
		dac_pm_e [1:0] pm;
		logic [1:0][31:0] wake_cnt;
		logic [1:0][12:0] word;
		logic [1:0][12:0] pipe0;
		logic [1:0][7:0]  lat_cnt;
		logic [1:0]       ready;
		logic [31:0]   stop_cnt;
		logic [7:0]    lock_cnt;
		logic          locked;
		logic [11:0]   bus_a_data;
		logic          bus_a_flag;
		logic          bus_a_oe;
		logic [11:0]   bus_b_data;
		logic          bus_b_flag;
		logic          bus_b_oe;
		logic          twos;
		logic          dcs;
	} dac_st_s;
	dac_st_s     st_q;
	dac_st_s     st_d;

	logic [1:0]        clk_in;
	logic [1:0]        rise;
	logic [1:0]        pd;
	logic [1:0]        oen;
	logic [1:0][11:0]  raw;
	logic [1:0]        ovr;
	logic [1:0]        und;
	logic [1:0]        run;
	logic [1:0][12:0]  coded;
	logic [1:0]        f_in_ready;
	logic [1:0]        f_out_valid;
	logic [1:0][12:0]  f_out_data;

	assign clk_in = {chan_b_sample_clock, chan_a_sample_clock};
	assign pd     = {chan_b_power_down, chan_a_power_down};
	assign oen    = {chan_b_output_enable_n, chan_a_output_enable_n};
	assign raw    = {chan_b_raw, chan_a_raw};
	// Each channel sees only its own range inputs
	assign ovr    = {chan_b_over, chan_a_over};
	assign und    = {chan_b_under, chan_a_under};

	////////////////////////////////////////////////////////////////////////
	// Per-channel coding and buffering
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic [11:0] ob;
			logic        oflag;
			// Only falling-to-rising matters; the falling edge is never used
			assign rise[g] = clk_in[g] && !st_q.clk_prev[g];
			assign run[g]  = (st_q.pm[g] == PM_RUN);
			assign oflag   = ovr[g] || und[g];
			always_comb begin
				if (ovr[g]) ob = CODE_POS_FS;
				else if (und[g]) ob = CODE_NEG_FS;
				else ob = raw[g];
			end
			// Two's complement flips only the top bit
			assign coded[g] = {oflag, ob[MSB_POS] ^ st_q.twos, ob[MSB_POS-1:0]};
			// Full FIFO drops pushes; the pipeline has no way to stall a sampler
			dac_fifo #(
				.WIDTH (13),
				.DEPTH (FIFO_DEPTH)
			) u_fifo (
				.sys_clk   (sys_clk),
				// Flushed outside run; after a wake the bus drives the held word until the first new word
				.srst      (srst || !run[g]),
				.in_valid  (rise[g] && run[g]),
				.in_ready  (f_in_ready[g]),
				.in_data   (coded[g]),
				.out_valid (f_out_valid[g]),
				.out_ready (rise[g] && st_q.ready[g]),
				.out_data  (f_out_data[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		st_d.clk_prev = clk_in;
		// Strap decode
		st_d.twos = (format_strap == STRAP_2THIRD) || (format_strap == STRAP_VDD);
		st_d.dcs  = (format_strap == STRAP_THIRD) || (format_strap == STRAP_2THIRD);
		// Stabilizer relock after long clock stop
		if (rise[0]) begin
			st_d.stop_cnt = '0;
			if (st_q.stop_cnt >= 32'(STOP_LONG_CYC)) begin
				st_d.locked   = 1'b0;
				st_d.lock_cnt = '0;
			end else if (!st_q.locked) begin
				st_d.lock_cnt = st_q.lock_cnt + 8'h01;
				if (st_q.lock_cnt == 8'(DCS_LOCK_CYC - 1)) st_d.locked = 1'b1;
			end
		end else if (st_q.stop_cnt < 32'(STOP_LONG_CYC)) begin
			st_d.stop_cnt = st_q.stop_cnt + 32'h1;
		end
		if (!st_q.dcs) st_d.locked = 1'b1;
		for (int c = 0; c < 2; c++) begin
			// Mode depends on this channel's pins only
			unique case (st_q.pm[c])
				PM_RUN: if (pd[c]) st_d.pm[c] = oen[c] ? PM_SLEEP : PM_NAP;
				PM_NAP, PM_SLEEP: begin
					if (!pd[c]) begin
						st_d.pm[c] = PM_WAKE;
						st_d.wake_cnt[c] = (st_q.pm[c] == PM_SLEEP) ? 32'(SLEEP_WAKE)
						                                            : 32'(NAP_WAKE);
					end
				end
				PM_WAKE: begin
					if (pd[c]) st_d.pm[c] = oen[c] ? PM_SLEEP : PM_NAP;
					else if (st_q.wake_cnt[c] <= 32'h1) st_d.pm[c] = PM_RUN;
					else st_d.wake_cnt[c] = st_q.wake_cnt[c] - 32'h1;
				end
			endcase
			// Fixed latency: first word leaves after PIPE_LATENCY samples
			if (st_q.pm[c] != PM_RUN) begin
				st_d.lat_cnt[c] = '0;
				st_d.ready[c]   = 1'b0;
			end else if (rise[c] && !st_q.ready[c]) begin
				st_d.lat_cnt[c] = st_q.lat_cnt[c] + 8'h01;
				if (st_q.lat_cnt[c] == 8'(PIPE_LATENCY - 1)) st_d.ready[c] = 1'b1;
			end
			if (rise[c] && st_q.ready[c] && f_out_valid[c]) st_d.word[c] = f_out_data[c];
		end
		// Bus routing: swap high keeps straight, low crosses
		if (bus_swap_select) begin
			{st_d.bus_a_flag, st_d.bus_a_data} = st_q.word[0];
			{st_d.bus_b_flag, st_d.bus_b_data} = st_q.word[1];
			st_d.bus_a_oe = !oen[0] && run[0];
			st_d.bus_b_oe = !oen[1] && run[1];
		end else begin
			{st_d.bus_a_flag, st_d.bus_a_data} = st_q.word[1];
			{st_d.bus_b_flag, st_d.bus_b_data} = st_q.word[0];
			st_d.bus_a_oe = !oen[1] && run[1];
			st_d.bus_b_oe = !oen[0] && run[0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q        <= '0;
			st_q.pm[0]  <= PM_RUN;
			st_q.pm[1]  <= PM_RUN;
			st_q.locked <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus_a_data        = st_q.bus_a_data;
	assign bus_a_range_flag  = st_q.bus_a_flag;
	assign bus_a_oe          = st_q.bus_a_oe;
	assign bus_b_data        = st_q.bus_b_data;
	assign bus_b_range_flag  = st_q.bus_b_flag;
	assign bus_b_oe          = st_q.bus_b_oe;
	assign twos_comp         = st_q.twos;
	assign stabilizer_on     = st_q.dcs;
	assign stabilizer_locked = st_q.locked;
	assign chan_a_valid      = {st_q.ready[0], st_q.pm[0] == PM_RUN};
	assign chan_b_valid      = {st_q.ready[1], st_q.pm[1] == PM_RUN};

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	strap_format_a: assert property (##1 twos_comp == $past(format_strap[1]))
		else $error("format does not follow strap");
	strap_dcs_a: assert property (##1 stabilizer_on == $past(^format_strap))
		else $error("stabilizer does not follow strap");
	sleep_entry_a: assert property (st_q.pm[0] == PM_RUN && pd[0] && oen[0]
		|=> st_q.pm[0] == PM_SLEEP)
		else $error("sleep not entered");
	nap_entry_a: assert property (st_q.pm[1] == PM_RUN && pd[1] && !oen[1]
		|=> st_q.pm[1] == PM_NAP)
		else $error("nap not entered");
	float_power_a: assert property (bus_swap_select && st_q.pm[0] != PM_RUN
		|=> !bus_a_oe)
		else $error("bus driven in low power");
	oe_off_a: assert property (!bus_swap_select && oen[1] |=> !bus_a_oe)
		else $error("bus driven with enable high");
	straight_route_a: assert property (bus_swap_select
		|=> bus_a_data == $past(st_q.word[0][11:0]))
		else $error("straight route wrong");
	cross_route_a: assert property (!bus_swap_select
		|=> bus_b_range_flag == $past(st_q.word[0][12]))
		else $error("crossed route wrong");
	sat_pos_a: assert property (chan_a_over |-> coded[0][11:0] == {!st_q.twos, 11'h7FF}
		&& coded[0][12])
		else $error("positive saturation wrong");
	mid_code_a: assert property (!chan_a_over && !chan_a_under && chan_a_raw == CODE_MID
		|-> coded[0][11] == !st_q.twos)
		else $error("mid code wrong");
	nap_wake_a: assert property (st_q.pm[0] == PM_NAP && !pd[0]
		|=> st_q.pm[0] == PM_WAKE ##1 (st_q.pm[0] != PM_RUN) [*8])
		else $error("nap recovered too fast");

	run_cov: cover property (st_q.pm[0] == PM_RUN && rise[0] && st_q.ready[0]);
	nap_cov: cover property (st_q.pm[1] == PM_WAKE ##1 st_q.pm[1] == PM_RUN);
	swap_cov: cover property (bus_swap_select ##1 !bus_swap_select);
endmodule
`default_nettype wire

// ===== logic/dac_pkg.sv
// Constants and types for the dual converter output stage.
// Assumes one system clock; sample clocks arrive as synchronous strobes.
package dac_pkg;
	localparam int             DATA_W         = 12;
	localparam logic [11:0]    CODE_MID       = 12'h800;
	localparam logic [11:0]    CODE_POS_FS    = 12'hFFF;
	localparam logic [11:0]    CODE_NEG_FS    = 12'h000;
	localparam int             MSB_POS        = 11;
	localparam int             NAP_WAKE_CYC   = 100;
	localparam int             DCS_LOCK_CYC   = 100;
	localparam int             SLEEP_WAKE_MS  = 1;
	localparam int             CLK_MHZ        = 200;
	localparam int             SLEEP_WAKE_CYC = SLEEP_WAKE_MS * CLK_MHZ * 1000;
	localparam int             STOP_LONG_CYC  = 1000;
	localparam int             PIPE_LAT       = 5;
	localparam int             FIFO_DEPTH     = 8;
	localparam logic [1:0]     STRAP_GND      = 2'h0;
	localparam logic [1:0]     STRAP_THIRD    = 2'h1;
	localparam logic [1:0]     STRAP_2THIRD   = 2'h2;
	localparam logic [1:0]     STRAP_VDD      = 2'h3;
	typedef enum logic [1:0] {PM_RUN, PM_NAP, PM_SLEEP, PM_WAKE} dac_pm_e;
endpackage

// ===== sim/dac_bus_capture.sv
// Far-side capture logic: latches each output bus while it is driven.
// Assumes bus outputs are registered on sys_clk rising edge.
`timescale 1ns/1ps
`default_nettype none
module dac_bus_capture (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Bus A pins
	input  wire logic [11:0] bus_a_data,
	input  wire logic        bus_a_range_flag,
	input  wire logic        bus_a_oe,
	// Bus B pins
	input  wire logic [11:0] bus_b_data,
	input  wire logic        bus_b_range_flag,
	input  wire logic        bus_b_oe,
	// Captured words, flag on top
	output logic [12:0]      word_a_q,
	output logic [12:0]      word_b_q
);
	// Floating pins read as Z, never as a stale word
	wire logic [12:0] pin_a = bus_a_oe ? {bus_a_range_flag, bus_a_data} : {13{1'bz}};
	wire logic [12:0] pin_b = bus_b_oe ? {bus_b_range_flag, bus_b_data} : {13{1'bz}};
	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			word_a_q <= 13'h0000;
			word_b_q <= 13'h0000;
		end else begin
			// Either bus may be used; a disabled bus keeps the last capture
			if (bus_a_oe) word_a_q <= pin_a;
			if (bus_b_oe) word_b_q <= pin_b;
		end
	end
endmodule
`default_nettype wire

// ===== sim/dual_adc_output_control_test.sv
// Self-checking bench for the converter output stage.
// Assumes dac_out_ctrl and dac_bus_capture; sample clocks driven as strobes.
`timescale 1ns/1ps
`default_nettype none
module dual_adc_output_control_test;
	import dac_pkg::*;
	typedef struct packed {logic [1:0] strap; logic swap; logic [11:0] raw; logic ov; logic un;} dac_row_s;
	logic sys_clk, srst, clk_a, clk_b, ov_a, un_a, oen_a, oen_b, pd_a, pd_b, swap;
	logic [11:0] raw_a, raw_b, da, db;
	logic [1:0]  strap, vld_a, vld_b;
	logic        fa, fb, oe_a, oe_b, twos, dcs, locked;
	logic [12:0] cap_a, cap_b, exp_a, exp_b;
	int          error_cnt, samples_checked;
	dac_row_s    rows [8] = '{
		'{2'h0, 1'b1, 12'h800, 1'b0, 1'b0}, '{2'h1, 1'b1, 12'h123, 1'b0, 1'b0},
		'{2'h2, 1'b1, 12'h800, 1'b0, 1'b0}, '{2'h3, 1'b0, 12'hABC, 1'b0, 1'b0},
		'{2'h0, 1'b1, 12'h555, 1'b1, 1'b0}, '{2'h0, 1'b0, 12'h555, 1'b0, 1'b1},
		'{2'h3, 1'b1, 12'h0AA, 1'b1, 1'b0}, '{2'h2, 1'b0, 12'h0AA, 1'b0, 1'b1}};

	dac_out_ctrl #(.SLEEP_WAKE(50)) dut_u (.sys_clk(sys_clk), .srst(srst),
		.chan_a_sample_clock(clk_a), .chan_b_sample_clock(clk_b),
		.chan_a_raw(raw_a), .chan_a_over(ov_a), .chan_a_under(un_a),
		.chan_b_raw(raw_b), .chan_b_over(1'b0), .chan_b_under(1'b0),
		.format_strap(strap), .chan_a_output_enable_n(oen_a), .chan_b_output_enable_n(oen_b),
		.chan_a_power_down(pd_a), .chan_b_power_down(pd_b), .bus_swap_select(swap),
		.bus_a_data(da), .bus_a_range_flag(fa), .bus_a_oe(oe_a),
		.bus_b_data(db), .bus_b_range_flag(fb), .bus_b_oe(oe_b),
		.twos_comp(twos), .stabilizer_on(dcs), .stabilizer_locked(locked),
		.chan_a_valid(vld_a), .chan_b_valid(vld_b));
	dac_bus_capture cap_u (.sys_clk(sys_clk), .srst(srst),
		.bus_a_data(da), .bus_a_range_flag(fa), .bus_a_oe(oe_a),
		.bus_b_data(db), .bus_b_range_flag(fb), .bus_b_oe(oe_b),
		.word_a_q(cap_a), .word_b_q(cap_b));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		samples_checked++;
		if (seen !== expv) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask
	task automatic summarize();
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// One sample on both channels every four cycles, within the spacing limit
	task automatic pulse(input int n);
		repeat (n) begin
			clk_a = 1'b1;
			clk_b = 1'b1;
			wait_cyc(2);
			clk_a = 1'b0;
			clk_b = 1'b0;
			wait_cyc(2);
		end
	endtask
	// Coding reference, worked from the output code table
	function automatic logic [12:0] enc(input logic [11:0] raw, input logic ov, un, tc);
		logic [11:0] w;
		w = ov ? CODE_POS_FS : (un ? CODE_NEG_FS : raw);
		if (tc) w[MSB_POS] = ~w[MSB_POS];
		return {ov | un, w};
	endfunction
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{clk_a, clk_b, ov_a, un_a, oen_a, oen_b, pd_a, pd_b} = 8'h00;
		{srst, swap, strap, raw_a, raw_b} = {1'b1, 1'b1, 2'h0, 24'h000000};
		error_cnt = 0;
		samples_checked = 0;
		wait_cyc(6);
		check({oe_a, oe_b, fa, fb, locked}, 16'h0001);
		check(da | db, 16'h0000);
		wait_cyc(6);
		srst = 1'b0;
		wait_cyc(2);
		// Constant input per row; enough samples to flush the pipeline
		foreach (rows[i]) begin
			{strap, swap, raw_a, ov_a, un_a} = rows[i];
			raw_b = ~rows[i].raw;
			pulse(8);
			wait_cyc(3);
			exp_a = enc(raw_a, ov_a, un_a, strap[1]);
			exp_b = enc(raw_b, 1'b0, 1'b0, strap[1]);
			check(cap_a, swap ? exp_a : exp_b);
			check(cap_b, swap ? exp_b : exp_a);
			check({twos, dcs}, {strap[1], strap == 2'h1 || strap == 2'h2});
		end
		check({vld_a, vld_b}, 16'h000F);
		// Output enable per channel, idle periods only
		{swap, ov_a, un_a} = 3'b100;
		oen_a = 1'b1;
		wait_cyc(3);
		check({oe_a, oe_b, vld_a[0]}, 16'h0003);
		oen_a = 1'b0;
		wait_cyc(3);
		check(oe_a, 16'h0001);
		// Nap on A while B keeps converting
		pd_a = 1'b1;
		wait_cyc(3);
		check({oe_a, vld_a[0], oe_b, vld_b[0]}, 16'h0003);
		pd_a = 1'b0;
		wait_cyc(90);
		check(vld_a[0], 16'h0000);
		wait_cyc(20);
		check(vld_a[0], 16'h0001);
		// Sleep on A: enable high first, then power down
		oen_a = 1'b1;
		wait_cyc(2);
		pd_a = 1'b1;
		wait_cyc(3);
		check({oe_a, vld_a[0], oe_b}, 16'h0001);
		pd_a = 1'b0;
		wait_cyc(40);
		check(vld_a[0], 16'h0000);
		wait_cyc(25);
		check(vld_a[0], 16'h0001);
		oen_a = 1'b0;
		// Long clock stop, then relock over about a hundred rises
		strap = 2'h1;
		wait_cyc(1010);
		// The first rise after the stop is what drops the lock
		pulse(1);
		check(locked, 16'h0000);
		pulse(90);
		check(locked, 16'h0000);
		pulse(15);
		check({locked, dcs}, 16'h0003);
		summarize();
	end
	// Tests need under 3000 cycles; the margin covers slow wake paths
	initial begin
		wait_cyc(20000);
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire
